// ===== core/isrc_cfg.svh
// Purpose: offsets, field positions, reset values for idle standby release control
// Assumes: 32-bit APB, word aligned registers
// Notes: included by bare name
`ifndef ISRC_CFG_SVH
`define ISRC_CFG_SVH
// ****************************************
// register offsets
// ****************************************
`define ISRC_OFS_POWER_SAVE_CONTROL 8'h00
`define ISRC_OFS_NOISE_FILTER_CONTROL 8'h04
`define ISRC_OFS_STATUS 8'h08
// ****************************************
// power save control fields
// ****************************************
`define ISRC_PSCTL_NMI1_MASK 0
`define ISRC_PSCTL_NMI0_MASK 1
`define ISRC_PSCTL_INT_MASK 2
`define ISRC_PSCTL_MODE_LO 4
`define ISRC_PSCTL_MODE_HI 5
`define ISRC_PSCTL_ENTER 7
`define ISRC_MODE_LIGHT 2'h1
`define ISRC_MODE_DEEP 2'h2
`define ISRC_PSCTL_RESET 8'h07
// ****************************************
// noise filter control fields
// ****************************************
`define ISRC_NFC_DIGITAL 0
`define ISRC_NFC_CLK_LO 1
`define ISRC_NFC_CLK_HI 3
`define ISRC_NFC_SLOW_MIN 3'h3
`define ISRC_NFC_RESET 4'h0
// ****************************************
// status fields
// ****************************************
`define ISRC_STAT_HALT 0
`define ISRC_STAT_LIGHT 1
`define ISRC_STAT_DEEP 2
`define ISRC_STAT_WOKE 3
`endif

// ===== core/isrc_pkg.sv
// Purpose: shared types for idle standby release control
// Assumes: nothing
// Notes: constants live in isrc_cfg.svh
package isrc_pkg;
    // ****************************************
    // request, mask and filter carriers
    // ****************************************
    typedef struct packed {
        logic nmi1;
        logic nmi0;
        logic maskable;
        logic ext_pin3;
    } isrc_req_s;
    typedef struct packed {
        logic second_nonmaskable_mask;
        logic first_nonmaskable_mask;
        logic maskable_interrupt_mask;
    } isrc_mask_s;
    typedef struct packed {
        logic digital;
        logic [2:0] clk_sel;
    } isrc_nf_s;
    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        ISRC_RUN   = 5'b00001,
        ISRC_ENTER = 5'b00010,
        ISRC_LIGHT = 5'b00100,
        ISRC_DEEP  = 5'b01000,
        ISRC_EXIT  = 5'b10000
    } isrc_state_e;
endpackage

// ===== core/isrc_wake_filter.sv
// Purpose: decide whether pending requests may release an idle state
// Assumes: request inputs are pending levels, synchronous to pclk
// Notes: result is registered, one cycle behind the inputs
`timescale 1ns/1ps
`default_nettype none
`include "isrc_cfg.svh"
module isrc_wake_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire isrc_pkg::isrc_req_s req,
    input wire isrc_pkg::isrc_mask_s mask,
    input wire isrc_pkg::isrc_nf_s nf,
    output logic wake
);
    import isrc_pkg::*;
    // ****************************************
    // slow sampling select
    // ****************************************
    function automatic logic slow_sampling(input isrc_nf_s f);
        slow_sampling = f.digital && (f.clk_sel >= `ISRC_NFC_SLOW_MIN);
    endfunction
    // RULE_03: masked sources ignored
    // RULE_07: masked sources ignored
    wire logic nmi1_ok = req.nmi1 && !mask.second_nonmaskable_mask;
    wire logic nmi0_ok = req.nmi0 && !mask.first_nonmaskable_mask;
    wire logic int_ok = req.maskable && !mask.maskable_interrupt_mask;
    // RULE_04: slow filter blocks pin
    // RULE_08: slow filter blocks pin
    // sampler clock is stopped in standby, so a slow filter never sees the edge
    wire logic pin3_ok = req.ext_pin3 && !mask.maskable_interrupt_mask && !slow_sampling(nf);
    wire logic wake_d = nmi1_ok || nmi0_ok || int_ok || pin3_ok;
    logic wake_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end
    assign wake = wake_q;
endmodule // isrc_wake_filter
`default_nettype wire

// ===== core/isrc_top.sv
// Purpose: light and deep idle standby entry and release sequencer with APB registers
// Assumes: cpu stalls while cpu_halt is high; request inputs are pending levels
// Notes: zero wait state APB slave; unmapped addresses answer pslverr
//
// Summary of operation
// RULE_01: software places five nops after the write entering light idle.
// RULE_02: light idle entered with a valid pending request is left at once.
// RULE_03: requests masked by any of the three mask bits never release light idle.
// RULE_04: pin 3 with slow digital filter sampling cannot release light idle.
// RULE_05: software places five nops after the write entering deep idle.
// RULE_06: deep idle entered with a valid pending request is left at once.
// RULE_07: requests masked by any of the three mask bits never release deep idle.
// RULE_08: pin 3 with slow digital filter sampling cannot release deep idle.
// RULE_09: cpu stays halted in idle until a valid release, then resumes.
`timescale 1ns/1ps
`default_nettype none
`include "isrc_cfg.svh"
module isrc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire isrc_pkg::isrc_req_s irq_req,
    output logic cpu_halt,
    output logic light_idle_active,
    output logic deep_idle_active,
    output logic standby_release
);
    import isrc_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    wire logic access = psel && penable;
    wire logic sel_psctl = (paddr == `ISRC_OFS_POWER_SAVE_CONTROL);
    wire logic sel_nfc = (paddr == `ISRC_OFS_NOISE_FILTER_CONTROL);
    wire logic sel_stat = (paddr == `ISRC_OFS_STATUS);
    wire logic mapped = sel_psctl || sel_nfc || sel_stat;
    wire logic wr_psctl = access && pwrite && sel_psctl;
    wire logic wr_nfc = access && pwrite && sel_nfc;
    wire logic wr_stat = access && pwrite && sel_stat;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] psctl_q;
    logic [3:0] nfc_q;
    logic woke_q;
    logic [31:0] prdata_q;
    isrc_state_e state_q;
    isrc_state_e state_d;
    logic [1:0] mode_q;
    logic release_q;
    logic wake;
    wire logic [1:0] wr_mode = pwdata[`ISRC_PSCTL_MODE_HI:`ISRC_PSCTL_MODE_LO];
    wire logic mode_ok = (wr_mode == `ISRC_MODE_LIGHT) || (wr_mode == `ISRC_MODE_DEEP);
    // entry only from run; a write while halted cannot come from the cpu anyway
    wire logic enter_req = wr_psctl && pwdata[`ISRC_PSCTL_ENTER] && mode_ok
        && (state_q == ISRC_RUN);

    // ****************************************
    // mask and filter carriers
    // ****************************************
    wire isrc_mask_s mask = '{
        second_nonmaskable_mask: psctl_q[`ISRC_PSCTL_NMI1_MASK],
        first_nonmaskable_mask: psctl_q[`ISRC_PSCTL_NMI0_MASK],
        maskable_interrupt_mask: psctl_q[`ISRC_PSCTL_INT_MASK]
    };
    wire isrc_nf_s nf = '{
        digital: nfc_q[`ISRC_NFC_DIGITAL],
        clk_sel: nfc_q[`ISRC_NFC_CLK_HI:`ISRC_NFC_CLK_LO]
    };
    isrc_wake_filter u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .req(irq_req),
        .mask(mask),
        .nf(nf),
        .wake(wake)
    );

    // ****************************************
    // state decode
    // ****************************************
    // one compare in one place, so status word and pins always agree
    function automatic logic in_state(input isrc_state_e s, input isrc_state_e t);
        in_state = (s == t);
    endfunction
    wire logic st_enter = in_state(state_q, ISRC_ENTER);
    wire logic st_light = in_state(state_q, ISRC_LIGHT);
    wire logic st_deep = in_state(state_q, ISRC_DEEP);
    wire logic st_exit = in_state(state_q, ISRC_EXIT);

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ISRC_RUN: begin
                if (enter_req) begin
                    state_d = ISRC_ENTER;
                end
            end
            ISRC_ENTER: begin
                // RULE_02: pending request releases light
                // RULE_06: pending request releases deep
                if (wake) begin
                    state_d = ISRC_EXIT;
                end else if (mode_q == `ISRC_MODE_DEEP) begin
                    state_d = ISRC_DEEP;
                end else begin
                    state_d = ISRC_LIGHT;
                end
            end
            ISRC_LIGHT: begin
                // RULE_09: hold until valid release
                if (wake) begin
                    state_d = ISRC_EXIT;
                end
            end
            ISRC_DEEP: begin
                // RULE_09: hold until valid release
                if (wake) begin
                    state_d = ISRC_EXIT;
                end
            end
            ISRC_EXIT: begin
                state_d = ISRC_RUN;
            end
            default: begin
                state_d = ISRC_RUN;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ISRC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    // enter bit is a trigger, never stored, so a read shows zero there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psctl_q <= `ISRC_PSCTL_RESET;
            nfc_q <= `ISRC_NFC_RESET;
            mode_q <= 2'h0;
        end else begin
            // only masks and mode are kept
            if (wr_psctl) begin
                psctl_q <= pwdata[7:0] & 8'h37;
            end
            if (wr_nfc) begin
                nfc_q <= pwdata[3:0];
            end
            if (enter_req) begin
                mode_q <= wr_mode;
            end
        end
    end

    // sticky woke flag: set wins over write-one clear
    wire logic woke_set = st_exit;
    wire logic woke_clr = wr_stat && pwdata[`ISRC_STAT_WOKE];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            woke_q <= 1'b0;
            release_q <= 1'b0;
        end else begin
            woke_q <= woke_set || (woke_q && !woke_clr);
            release_q <= woke_set;
        end
    end
    // ****************************************
    // outputs and read data
    // ****************************************
    // RULE_01: halt from the cycle after entry write
    // RULE_05: halt from the cycle after entry write
    wire logic halted = st_enter || st_light || st_deep;
    wire logic [31:0] stat_word = {28'h0000000, woke_q, st_deep, st_light, halted};
    wire logic [31:0] rd_mux = sel_psctl ? {24'h000000, psctl_q} :
        sel_nfc ? {28'h0000000, nfc_q} :
        sel_stat ? stat_word : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    // ****************************************
    // bus response
    // ****************************************
    // no wait states: every register answers in its first access cycle
    assign pready = 1'b1;
    // unmapped offsets flag an error and store nothing
    assign pslverr = access && !mapped;

    // ****************************************
    // standby pins
    // ****************************************
    // RULE_09: cpu held while halted
    assign cpu_halt = halted;
    assign light_idle_active = st_light;
    assign deep_idle_active = st_deep;
    // RULE_09: one-cycle release pulse
    assign standby_release = release_q;
endmodule // isrc_top
`default_nettype wire

// ===== verif/isrc_irq_src.sv
// Purpose: interrupt sources seen by the core
// Assumes: bench strobes raise for one cycle
// Notes: pending until the core is released
`timescale 1ns/1ps
`default_nettype none
module isrc_irq_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire isrc_pkg::isrc_req_s raise,
    input wire logic standby_release,
    output isrc_pkg::isrc_req_s irq_req
);
    import isrc_pkg::*;
    // held pending
    // serviced on release, so a stale level cannot re-wake the next entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= '0;
        end else if (standby_release) begin
            irq_req <= raise;
        end else begin
            irq_req <= irq_req | raise;
        end
    end
endmodule // isrc_irq_src
`default_nettype wire

// ===== verif/isrc_top_assertions.sv
// Purpose: port checker for idle release
// Assumes: masks shadowed from apb writes
// Notes: bound to isrc_top
`timescale 1ns/1ps
`default_nettype none
module isrc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire isrc_pkg::isrc_req_s irq_req,
    input wire logic cpu_halt,
    input wire logic light_idle_active,
    input wire logic deep_idle_active,
    input wire logic standby_release
);
    import isrc_pkg::*;
    logic [5:0] ps_q;
    logic [3:0] nf_q;
    logic wr, slow, ok, pin;
    assign wr = psel & penable & pwrite;
    assign slow = nf_q[0] & (nf_q[3:1] >= 3'h3);
    assign pin = (irq_req == 4'h1) & slow;
    assign ok = (irq_req.nmi1 & ~ps_q[0]) | (irq_req.nmi0 & ~ps_q[1])
        | ((irq_req.maskable | (irq_req.ext_pin3 & ~slow)) & ~ps_q[2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_q <= 6'h07;
            nf_q <= 4'h0;
        end else if (wr && paddr == 8'h00) begin
            ps_q <= pwdata[5:0];
        end else if (wr && paddr == 8'h04) begin
            nf_q <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence seq_exit;
        !cpu_halt ##1 standby_release ##1 !standby_release;
    endsequence
    sequence seq_skip;
        !light_idle_active && !deep_idle_active ##1 seq_exit;
    endsequence
    AST_LIGHT_PENDING: assert property ($rose(cpu_halt) && $past(ok) && ps_q[5:4] == 2'h1
        |-> seq_skip) else $error("light entry not skipped");
    AST_DEEP_PENDING: assert property ($rose(cpu_halt) && $past(ok) && ps_q[5:4] == 2'h2
        |-> seq_skip) else $error("deep entry not skipped");
    AST_LIGHT_MASKED: assert property (light_idle_active && !ok && !$past(ok)
        |=> light_idle_active) else $error("light left without request");
    AST_DEEP_MASKED: assert property (deep_idle_active && !ok && !$past(ok)
        |=> deep_idle_active) else $error("deep left without request");
    AST_LIGHT_PIN3: assert property (light_idle_active && pin && $past(pin)
        |=> light_idle_active) else $error("slow pin left light");
    AST_DEEP_PIN3: assert property (deep_idle_active && pin && $past(pin)
        |=> deep_idle_active) else $error("slow pin left deep");
    AST_IDLE_RELEASE: assert property ((light_idle_active || deep_idle_active) && ok
        && !$past(ok) |-> ##2 seq_exit) else $error("idle not released");
    AST_RELEASE_PULSE: assert property ($fell(cpu_halt) |-> seq_exit)
        else $error("release pulse wrong");
endmodule // isrc_checker
bind isrc_top isrc_checker isrc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .irq_req, .cpu_halt, .light_idle_active, .deep_idle_active,
    .standby_release);
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for idle release
// Assumes: zero wait apb slave
// Notes: nop slots modelled as idle cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import isrc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, seen;
    logic cpu_halt, light_idle_active, deep_idle_active, standby_release;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, mk;
    isrc_req_s irq_req, raise;
    int errors, checks, cyc, hcnt;
    isrc_top isrc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_req, .cpu_halt, .light_idle_active,
        .deep_idle_active, .standby_release);
    isrc_irq_src isrc_irq_src_i (.pclk, .presetn, .raise, .standby_release, .irq_req);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic give_verdict;
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rel;
        for (int i = 0; i < 20 && standby_release !== 1'b1; i++) @(negedge pclk);
        chk("standby_release", 32'h1, {31'h0, standby_release});
    endtask
    // hang guard well above the few hundred cycles needed
    // sampled mid-cycle so registered outputs are settled
    always @(negedge pclk) begin
        cyc++;
        if (cpu_halt === 1'b1) hcnt++;
        if (light_idle_active || deep_idle_active) seen = 1'b1;
        if (cyc == 4000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, seen} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        raise = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("power_save_control", 32'h07, r);
        apb(1'b0, 8'h04, 32'h0);
        chk("noise_filter_control", 32'h0, r);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        for (int m = 1; m < 3; m++) begin
            for (int k = 0; k < 4; k++) begin
                mk = (k < 3) ? (32'h1 << k) : 32'h0;
                apb(1'b1, 8'h04, (k == 3) ? 32'h7 : 32'h0);
                apb(1'b1, 8'h00, mk);
                raise <= 4'h8 >> k;
                @(posedge pclk);
                raise <= '0;
                apb(1'b1, 8'h00, mk | (32'(m) << 4) | 32'h80);
                repeat (5) @(posedge pclk);
                repeat (4) @(negedge pclk);
                chk("idle held", 32'(m), {deep_idle_active, light_idle_active});
                if (k < 3) apb(1'b1, 8'h00, 32'h0);
                else apb(1'b1, 8'h04, 32'h0);
                wait_rel();
                chk("cpu_halt", 32'h0, {31'h0, cpu_halt});
                apb(1'b0, 8'h08, 32'h0);
                chk("status", 32'h8, r);
                apb(1'b1, 8'h08, 32'h8);
            end
            raise <= 4'h4;
            @(posedge pclk);
            raise <= '0;
            hcnt = 0;
            seen = 1'b0;
            apb(1'b1, 8'h00, (32'(m) << 4) | 32'h80);
            wait_rel();
            chk("halt cycles", 32'h1, hcnt);
            chk("idle seen", 32'h0, {31'h0, seen});
            apb(1'b1, 8'h08, 32'h8);
        end
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
